// File: sim/pcs_pma_port_interface_test.sv
`timescale 1ns/1ps
`include "ppi_map.svh"
// ----
// bench top
// ----
module pcs_pma_port_interface_test;
  logic        CLK, RESETN, mdc, mdo, seen, rx_valid, present, fault, txdis, up, low, ce, cc;
  logic [7:0]  tx_ctrl, rx_ctrl;
  logic [31:0] tx_word, tx_word_f, rx_word;
  logic [63:0] tx_data, rx_data, r;
  logic [63:0] q[$];
  int          num_errors, n_compared;
  ppi_if link ();
  ppi_mac_end ppi_mac_end_i (.CLK(CLK), .RESETN(RESETN), .CE(ce), .LINK(link.mac),
    .TX_DATA(tx_data), .TX_CTRL(tx_ctrl), .RX_DATA(rx_data), .RX_CTRL(rx_ctrl),
    .MDC_IN(mdc), .MDIO_DRIVE(mdo), .MDIO_SEEN(seen));
  ppi_dev_end ppi_dev_end_i (.CLK(CLK), .RESETN(RESETN), .CE(ce), .LINK(link.dev),
    .SERDES_TX_WORD(tx_word), .SERDES_RX_WORD(rx_word), .SERDES_RX_VALID(rx_valid),
    .RX_IS_CLOCK_CORRECTION(cc), .PORT_ADDR(5'h05), .LINK_PRESENT(present),
    .TX_FAULT(fault), .TX_DISABLE(txdis), .LINK_UP(up));
  // second device end with both latency options, fed the same words
  ppi_if link_fec ();
  assign link_fec.txd      = link.txd;
  assign link_fec.txc      = link.txc;
  assign link_fec.mdc      = 1'b0;
  assign link_fec.mdio_m2d = 1'b1;
  ppi_dev_end #(.FEC(1'b1), .FEC_ERR(1'b1)) ppi_dev_end_fec_i (.CLK(CLK), .RESETN(RESETN),
    .CE(ce), .LINK(link_fec.dev), .SERDES_TX_WORD(tx_word_f), .SERDES_RX_WORD(rx_word),
    .SERDES_RX_VALID(rx_valid), .RX_IS_CLOCK_CORRECTION(cc), .PORT_ADDR(5'h05),
    .LINK_PRESENT(present), .TX_FAULT(fault), .TX_DISABLE(), .LINK_UP());
  ppi_checker ppi_checker_i (.CLK(CLK), .RESETN(RESETN), .txd(link.txd), .txc(link.txc),
    .rxd(link.rxd), .rxc(link.rxc), .mdc(link.mdc), .mdio_d2m(link.mdio_d2m),
    .mdio_tri(link.mdio_tri));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task results;
    $display("errors %0d of %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // wide mdc phases leave room for the two-clock sampling on both ends
  task frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] d);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'h1, op, pa, 5'h01, op[1] ? 2'h3 : 2'h2, d};
    low = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      @(posedge CLK) mdc <= 1'b0;
      mdo <= f[i];
      cyc(6);
      #1 r[i] = seen;
      low = low | !link.mdio_tri;
      @(posedge CLK) mdc <= 1'b1;
      cyc(5);
    end
  endtask
  task t_tx;
    logic [15:0] k;
    for (int i = 0; i < 50; i++) begin
      k = i[15:0];
      @(posedge CLK) tx_data <= {16'hA5A5, k, 16'h5A5A, k};
      @(negedge CLK) q.push_back(link.txd);
      // phase toggles from reset: even takes carry the high half
      if (i >= 20)
        chk(tx_word, i[0] ? q[i-20][31:0] : q[i-20][63:32]);
      if (i >= 26)
        chk(tx_word_f, i[0] ? q[i-26][31:0] : q[i-26][63:32]);
    end
  endtask
  task t_rx;
    int hit, hit_f, fill;
    hit   = 0;
    hit_f = 0;
    fill  = 0;
    for (int n = 0; n < 220; n++) begin
      @(posedge CLK) rx_valid <= 1'b1;
      rx_word <= n[0] ? 32'h2468ACE0 : 32'h13579BDF;
      cc <= (n == 41);
      #1;
      if (hit == 0 && rx_data === {32'h2468ACE0, 32'h13579BDF})
        hit = n;
      if (hit_f == 0 && link_fec.rxd === {32'h2468ACE0, 32'h13579BDF})
        hit_f = n;
      if (rx_data === `PPI_IDLE_DATA && rx_ctrl === `PPI_IDLE_CTRL)
        fill++;
    end
    // two bench cycles before the pair is taken, one mac register after on rx_data, none on link_fec.rxd
    chk(hit >= 31 && hit <= 45, 1'b1);
    chk(hit_f >= 166 && hit_f <= 180, 1'b1);
    chk(fill > 0, 1'b1);
    @(posedge CLK) rx_valid <= 1'b0;
    cc <= 1'b0;
    cyc(300);
    chk(rx_data, `PPI_LF_DATA);
    chk(rx_ctrl, `PPI_LF_CTRL);
  endtask
  task t_mdio;
    frame(`PPI_OP_WRITE, 5'h05, 16'hA5B5);
    chk(txdis, 1'b1);
    frame(`PPI_OP_READ, 5'h05, 16'hFFFF);
    chk(r[16:0], 17'h0A5B5);
    chk(low, 1'b1);
    frame(`PPI_OP_WRITE, 5'h0A, 16'h0000);
    chk(txdis, 1'b1);
    frame(`PPI_OP_READ, 5'h0A, 16'hFFFF);
    chk(low, 1'b0);
    chk(r[16:0], 17'h1FFFF);
    frame(`PPI_OP_WRITE, 5'h05, 16'h0000);
    chk(txdis, 1'b0);
  endtask
  task t_up;
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK) present <= i[1];
      fault <= i[0];
      cyc(2);
      #1 chk(up, i[1] & ~i[0]);
    end
  endtask
  // low enable must hold the old status even though the inputs moved
  task t_ce;
    @(posedge CLK) ce <= 1'b0;
    fault <= 1'b0;
    cyc(4);
    #1 chk(up, 1'b0);
    @(posedge CLK) ce <= 1'b1;
    cyc(2);
    #1 chk(up, 1'b1);
  endtask
  initial begin
    {RESETN, mdc, rx_valid, fault, cc, tx_data, tx_ctrl, rx_word} = '0;
    {mdo, present, ce} = 3'h7;
    cyc(3);
    @(negedge CLK);
    chk(tx_word, 32'h0);
    chk(link.rxd, `PPI_LF_DATA);
    chk(txdis, 1'b0);
    @(posedge CLK) RESETN <= 1'b1;
    t_tx;
    t_rx;
    t_mdio;
    t_up;
    t_ce;
    results;
  end
  initial begin
    cyc(10000);
    num_errors++;
    $display("wrong value at %0t: run hung", $time);
    results;
  end
endmodule

// File: sim/ppi_checker.sv
`timescale 1ns/1ps
`include "ppi_map.svh"
// ----
// link checks
// ----
module ppi_checker (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic [63:0] txd,
  input wire logic [7:0]  txc,
  input wire logic [63:0] rxd,
  input wire logic [7:0]  rxc,
  input wire logic        mdc,
  input wire logic        mdio_d2m,
  input wire logic        mdio_tri
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_tri_reset_rel: assert property (
    $rose(RESETN) |-> mdio_tri && mdio_d2m) else $error("tri held after reset");
  a_rx_reset_fault: assert property (
    $rose(RESETN) |-> rxd == `PPI_LF_DATA && rxc == `PPI_LF_CTRL) else $error("no fault");
  a_tx_idle_start: assert property (
    $rose(RESETN) |-> txd == `PPI_IDLE_DATA && txc == `PPI_IDLE_CTRL) else $error("tx busy");
  a_ta_drive_zero: assert property (
    $fell(mdio_tri) |-> !mdio_d2m) else $error("turnaround not zero");
  a_tri_low_bounded: assert property (
    $fell(mdio_tri) |-> ##[1:1000] mdio_tri) else $error("driver never released");
  a_tri_fall_mdc: assert property (
    $fell(mdio_tri) |-> mdc) else $error("drive not in mdc high");
  a_d2m_on_mdc: assert property (
    $changed(mdio_d2m) && !mdio_tri && !$past(mdio_tri) |-> mdc) else $error("data off mdc");
  a_fault_word_pair: assert property (
    rxc == `PPI_LF_CTRL |-> rxd == `PPI_LF_DATA) else $error("bad fault word");
endmodule

// File: src/ppi_dev_end.sv
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_dev_end
  import ppi_pkg::*;
#(
  parameter bit FEC     = 1'b0,
  parameter bit FEC_ERR = 1'b0
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  ppi_if.dev               LINK,
  output logic      [31:0] SERDES_TX_WORD,
  input  wire logic [31:0] SERDES_RX_WORD,
  input  wire logic        SERDES_RX_VALID,
  input  wire logic        RX_IS_CLOCK_CORRECTION,
  input  wire logic [4:0]  PORT_ADDR,
  input  wire logic        LINK_PRESENT,
  input  wire logic        TX_FAULT,
  output logic             TX_DISABLE,
  output logic             LINK_UP
);
  localparam int TXL   = FEC ? `PPI_TX_LAT_FEC : `PPI_TX_LAT;
  localparam int RXL   = `PPI_RX_LAT + (FEC ? `PPI_RX_FEC_ADD : 0)
                       + ((FEC && FEC_ERR) ? `PPI_RX_ERR_ADD : 0);
  localparam int TXMAX = `PPI_TX_LAT_FEC;
  localparam int RXMAX = `PPI_RX_LAT + `PPI_RX_FEC_ADD + `PPI_RX_ERR_ADD;
  typedef struct packed {
    logic [TXMAX-1:0][31:0] txp;
    logic                   thalf;
    logic [RXMAX-1:0][71:0] rxp;
    logic [31:0]            rlo;
    logic                   rhalf;
    logic [4:0]             wp;
    logic [4:0]             rp;
    logic [5:0]             cnt;
    logic [63:0]            rxd;
    logic [7:0]             rxc;
    logic                   mdc;
    logic                   mdi;
    ppi_md_t                md;
    logic [5:0]             bit_n;
    logic [13:0]            hdr;
    logic [15:0]            sh;
    logic                   hit;
    logic                   rd;
    logic [15:0]            ctl;
    logic                   mdo;
    logic                   tri_n;
    logic                   txdis;
    logic                   up;
  } ppi_dst_t;
  ppi_dst_t   st_r, st_nxt;
  // deep storage kept outside the state struct as an array
  logic [71:0] eb_mem [`PPI_EB_DEPTH];
  logic        eb_wr;
  logic [71:0] eb_out;
  assign eb_out = eb_mem[st_r.rp];
  always_ff @(posedge CLK) begin
    if (CE && eb_wr) begin
      eb_mem[st_r.wp] <= st_r.rxp[RXL-1];
    end
  end
  always_comb begin
    st_nxt = st_r;
    eb_wr  = 1'b0;
    if (CE) begin
      // --------------------------------
      // transmit: 64-bit word split, fixed delay line
      // --------------------------------
      st_nxt.thalf = ~st_r.thalf;
      st_nxt.txp[0] = st_r.thalf ? LINK.txd[63:32] : LINK.txd[31:0];
      for (int i = 1; i < TXMAX; i++) begin
        st_nxt.txp[i] = st_r.txp[i-1];
      end
      // --------------------------------
      // receive: pair serdes words, delay, elastic buffer
      // --------------------------------
      if (SERDES_RX_VALID) begin
        st_nxt.rhalf = ~st_r.rhalf;
        st_nxt.rlo   = SERDES_RX_WORD; // alignment shifts latency
      end
      st_nxt.rxp[0] = {st_r.rhalf & SERDES_RX_VALID, RX_IS_CLOCK_CORRECTION, 6'h00,
                       SERDES_RX_WORD, st_r.rlo};
      for (int i = 1; i < RXMAX; i++) begin
        st_nxt.rxp[i] = st_r.rxp[i-1];
      end
      // drop correction words above half, so fill stays near center
      if (st_r.rxp[RXL-1][71] && st_r.cnt < 6'(`PPI_EB_DEPTH)
          && !(st_r.rxp[RXL-1][70] && st_r.cnt > 6'(`PPI_EB_HALF))) begin
        eb_wr     = 1'b1;
        st_nxt.wp = st_r.wp + 5'h01;
      end
      if (st_r.cnt == 6'h00) begin
        st_nxt.rxd = `PPI_LF_DATA;
        st_nxt.rxc = `PPI_LF_CTRL;
      end else if (st_r.cnt < 6'(`PPI_EB_HALF) && eb_out[70]) begin
        st_nxt.rxd = `PPI_IDLE_DATA; // repeat correction, read held
        st_nxt.rxc = `PPI_IDLE_CTRL;
      end else begin
        st_nxt.rxd = {32'h0, eb_out[31:0]} | {eb_out[63:32], 32'h0};
        st_nxt.rxc = {8{eb_out[70]}};
        st_nxt.rp  = st_r.rp + 5'h01;
      end
      st_nxt.cnt = st_r.cnt + {5'h00, eb_wr} - {5'h00, st_nxt.rp != st_r.rp};
      st_nxt.up  = LINK_PRESENT & ~TX_FAULT;
      // --------------------------------
      // management slave, sampled on mdc rising edge
      // --------------------------------
      st_nxt.mdc = LINK.mdc;
      st_nxt.mdi = LINK.mdio_m2d;
      if (LINK.mdc && !st_r.mdc) begin
        unique case (st_r.md)
          MD_PRE: begin
            st_nxt.tri_n = 1'b1;
            if (st_r.mdi) begin
              st_nxt.bit_n = (st_r.bit_n == 6'h3F) ? st_r.bit_n : st_r.bit_n + 6'h01;
            end else if (st_r.bit_n >= 6'(`PPI_PRE_BITS)) begin
              st_nxt.md    = MD_HDR;
              st_nxt.bit_n = 6'h00;
            end else begin
              st_nxt.bit_n = 6'h00;
            end
          end
          MD_HDR: begin
            st_nxt.hdr   = {st_r.hdr[12:0], st_r.mdi};
            st_nxt.bit_n = st_r.bit_n + 6'h01;
            if (st_r.bit_n == 6'h0C) begin
              // twelve bits held here: st1, op, prtad, devad[4:1]
              st_nxt.hit   = st_r.hdr[8:4] == PORT_ADDR;
              st_nxt.rd    = st_r.hdr[10]; // op msb set on both read kinds
              st_nxt.md    = MD_TA;
              st_nxt.bit_n = 6'h00;
            end
          end
          MD_TA: begin
            st_nxt.bit_n = st_r.bit_n + 6'h01;
            if (st_r.bit_n == 6'h01) begin
              st_nxt.md    = st_r.rd ? MD_RDAT : MD_WDAT;
              st_nxt.bit_n = 6'h00;
              if (st_r.rd && st_r.hit) begin
                // msb must stand before the first data edge samples it
                st_nxt.mdo = st_r.sh[15];
                st_nxt.sh  = {st_r.sh[14:0], 1'b0};
              end
            end
            if (st_r.rd && st_r.hit && st_r.bit_n == 6'h00) begin
              st_nxt.tri_n = 1'b0; // second turnaround bit driven zero
              st_nxt.mdo   = 1'b0;
              st_nxt.sh    = st_r.ctl;
            end
          end
          MD_RDAT: begin
            st_nxt.bit_n = st_r.bit_n + 6'h01;
            // other ports stay quiet: point-to-point has no tri buffer
            if (st_r.hit) begin
              st_nxt.mdo = st_r.sh[15];
              st_nxt.sh  = {st_r.sh[14:0], 1'b0};
            end
            if (st_r.bit_n == 6'h0F) begin
              st_nxt.tri_n = 1'b1; // release after last data bit
              st_nxt.mdo   = 1'b1;
              st_nxt.md    = MD_PRE;
              st_nxt.bit_n = 6'h00;
            end
          end
          MD_WDAT: begin
            st_nxt.sh    = {st_r.sh[14:0], st_r.mdi};
            st_nxt.bit_n = st_r.bit_n + 6'h01;
            if (st_r.bit_n == 6'h0F) begin
              if (st_r.hit) begin
                st_nxt.ctl = {st_r.sh[14:0], st_r.mdi};
              end
              st_nxt.md    = MD_PRE;
              st_nxt.bit_n = 6'h00;
            end
          end
        endcase
      end
      st_nxt.txdis = st_nxt.ctl[`PPI_TXDIS_BIT];
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r       <= '0;
      st_r.mdi   <= 1'b1;
      st_r.mdo   <= 1'b1;
      st_r.tri_n <= 1'b1;
      st_r.rxd   <= `PPI_LF_DATA;
      st_r.rxc   <= `PPI_LF_CTRL;
      st_r.md    <= MD_PRE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign SERDES_TX_WORD = st_r.txp[TXL-1];
  assign LINK.rxd       = st_r.rxd;
  assign LINK.rxc       = st_r.rxc;
  assign LINK.mdio_d2m  = st_r.mdo;
  assign LINK.mdio_tri  = st_r.tri_n;
  assign TX_DISABLE     = st_r.txdis;
  assign LINK_UP        = st_r.up;
endmodule

// File: src/ppi_if.sv
`timescale 1ns/1ps
interface ppi_if;
  logic [63:0] txd;
  logic [7:0]  txc;
  logic [63:0] rxd;
  logic [7:0]  rxc;
  logic        mdc;
  logic        mdio_m2d;
  logic        mdio_d2m;
  logic        mdio_tri;
  modport dev (input txd, txc, mdc, mdio_m2d, output rxd, rxc, mdio_d2m, mdio_tri);
  modport mac (output txd, txc, mdc, mdio_m2d, input rxd, rxc, mdio_d2m, mdio_tri);
endinterface

// File: src/ppi_mac_end.sv
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_mac_end
  import ppi_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        CE,
  ppi_if.mac               LINK,
  input  wire logic [63:0] TX_DATA,
  input  wire logic [7:0]  TX_CTRL,
  output logic      [63:0] RX_DATA,
  output logic      [7:0]  RX_CTRL,
  input  wire logic        MDC_IN,
  input  wire logic        MDIO_DRIVE,
  output logic             MDIO_SEEN
);
  typedef struct packed {
    logic [63:0] txd;
    logic [7:0]  txc;
    logic [63:0] rxd;
    logic [7:0]  rxc;
    logic        mdc;
    logic        mdo;
    logic        mdi;
  } ppi_mst_t;
  ppi_mst_t st_r, st_nxt;
  // --------------------------------
  // single-rate words, core clock
  // --------------------------------
  always_comb begin
    st_nxt = st_r;
    if (CE) begin
      st_nxt.txd = TX_DATA; // single rate kept, any ddr step sits outside
      st_nxt.txc = TX_CTRL;
      st_nxt.rxd = LINK.rxd;
      st_nxt.rxc = LINK.rxc;
      st_nxt.mdc = MDC_IN;
      st_nxt.mdo = MDIO_DRIVE;
      st_nxt.mdi = LINK.mdio_d2m; // point-to-point, tri unused
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '{txd: `PPI_IDLE_DATA, txc: `PPI_IDLE_CTRL, rxd: 64'h0, rxc: 8'h00,
                mdc: 1'b0, mdo: 1'b1, mdi: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign LINK.txd      = st_r.txd;
  assign LINK.txc      = st_r.txc;
  assign LINK.mdc      = st_r.mdc;
  assign LINK.mdio_m2d = st_r.mdo;
  assign RX_DATA       = st_r.rxd;
  assign RX_CTRL       = st_r.rxc;
  assign MDIO_SEEN     = st_r.mdi;
endmodule

// File: src/ppi_map.svh
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH
`define PPI_DW           64
`define PPI_CW           8
`define PPI_SW           32
`define PPI_TX_LAT       20
`define PPI_TX_LAT_FEC   26
`define PPI_RX_LAT       28
`define PPI_RX_FEC_ADD   70
`define PPI_RX_ERR_ADD   66
`define PPI_EB_DEPTH     32
`define PPI_EB_HALF      16
`define PPI_LF_DATA      64'h0100009C0100009C
`define PPI_LF_CTRL      8'h11
`define PPI_IDLE_DATA    64'h0707070707070707
`define PPI_IDLE_CTRL    8'hFF
`define PPI_OP_WRITE     2'h1
`define PPI_OP_READ      2'h3
`define PPI_OP_ADDR      2'h0
`define PPI_TXDIS_BIT    0
`define PPI_PRE_BITS     32
`endif

// File: src/ppi_pkg.sv
package ppi_pkg;
  typedef enum logic [2:0] {MD_PRE, MD_HDR, MD_TA, MD_RDAT, MD_WDAT} ppi_md_t;
endpackage
